// ---- pkg/pcl_params.svh ----
`ifndef PCPL_PARAMS_SVH
`define PCPL_PARAMS_SVH
// data-memory addresses of the two visible registers
`define PCPL_ADDR_LOW    8'h02
`define PCPL_ADDR_LATCH  8'h03
// reset values
`define PCPL_RST_PC      16'h0000
`define PCPL_RST_LATCH   8'h00
// field positions
`define PCPL_SHORT_MSB   12
`define PCPL_PAGE_LSB    13
`endif

// ---- pkg/pcl_pkg.sv ----
`default_nettype none
package pcpl_pkg;
  // program-flow operation requested by the decoder for this cycle
  typedef enum logic [3:0] {
    PCPL_OP_SEQ,
    PCPL_OP_SKIP,
    PCPL_OP_LONG_CALL,
    PCPL_OP_SHORT_JUMP,
    PCPL_OP_RETURN,
    PCPL_OP_RET_KEEP,
    PCPL_OP_VECTOR,
    PCPL_OP_HOLD
  } pcpl_op_t;

  // one decoder request
  typedef struct packed {
    pcpl_op_t    op;
    logic [12:0] opcode;
  } pcpl_req_t;

  // data-memory access to the register file
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcpl_bus_t;
endpackage
`default_nettype wire

// ---- rtl/pcl_page_latch.sv ----
// Functional notes
// - A 16-bit fetch address is kept and its low byte is readable and writable at address 02h.
// - The high byte is not addressable and is reached only through the holding latch at address 03h.
// - The address increments on each first clock phase unless a hold request keeps it or a branch, call, return, vector or low-byte write loads it.
// - A skipped instruction costs one forced no-operation cycle at the skipped address.
// - A long call loads the low byte from opcode bits 7..0 and the high byte from the latch, latch unchanged.
// - Reading the low byte drives it on the data bus and copies the high byte into the latch.
// - Writing the low byte in a first clock phase with no wake stores the bus value and loads the high byte from the latch.
// - A low-byte read-modify-write never updates the latch; in a first clock phase with no wake it stores the result and loads the high byte from the latch.
// - A return copies the high byte into the latch and loads all 16 bits from the most recent stack entry.
// - A short call or jump loads bits 12..0 from the opcode and sets the latch to old bits 15..13 and opcode bits 12..8.
// - Long calls, literal returns, interrupt returns, vector forcing and low-byte read-modify-writes keep the latch.
// - Resets clear the fetch address; wake-up by interrupt gives the next sequential address.
// - Wake-up by interrupt with global interrupts enabled loads the interrupt vector instead.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_params.svh"
module pcpl_page_latch
  import pcpl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        first_clock_phase_i,
  input  var  pcpl_req_t   req_i,
  input  var  pcpl_bus_t   bus_i,
  input  wire logic [15:0] most_recent_stack_entry_i,
  input  wire logic [15:0] int_vector_i,
  input  wire logic        wake_i,
  input  wire logic        global_interrupt_disable_i,
  output logic      [15:0] fetch_addr_o,
  output logic      [7:0]  fetch_high_holding_latch_o,
  output logic      [7:0]  rdata_o,
  output logic             rdata_valid_o,
  output logic             forced_nop_o
);

  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0]  latch_q;
  logic [7:0]  latch_d;
  logic        low_wr;
  logic        low_rd;
  logic        latch_wr;

  // decode of one data-memory address
  function automatic logic hit(input pcpl_bus_t b, input logic [7:0] a);
    hit = (b.addr == a);
  endfunction

  // a plain read copies the high byte; rmw must not, else the page would change mid-jump
  assign low_rd   = bus_i.rd && !bus_i.rmw && hit(bus_i, `PCPL_ADDR_LOW);
  assign low_wr   = (bus_i.wr || bus_i.rmw) && hit(bus_i, `PCPL_ADDR_LOW);
  assign latch_wr = bus_i.wr && hit(bus_i, `PCPL_ADDR_LATCH);

  // next fetch address; moves on the first clock phase or on a wake
  always_comb
  begin
    pc_d = pc_q;
    if (wake_i)
    begin
      if (!global_interrupt_disable_i)
        pc_d = int_vector_i;
      else
        pc_d = pc_q + 16'h0001;
    end
    else if (first_clock_phase_i)
    begin
      if (low_wr)
        pc_d = {latch_q, bus_i.wdata};
      else
      begin
        case (req_i.op)
          PCPL_OP_SEQ:        pc_d = pc_q + 16'h0001;
          PCPL_OP_SKIP:       pc_d = pc_q + 16'h0001;
          PCPL_OP_LONG_CALL:  pc_d = {latch_q, req_i.opcode[7:0]};
          PCPL_OP_SHORT_JUMP: pc_d = {pc_q[15:`PCPL_PAGE_LSB], req_i.opcode};
          PCPL_OP_RETURN:     pc_d = most_recent_stack_entry_i;
          PCPL_OP_RET_KEEP:   pc_d = most_recent_stack_entry_i;
          PCPL_OP_VECTOR:     pc_d = int_vector_i;
          PCPL_OP_HOLD:       pc_d = pc_q;
          default:            pc_d = pc_q;
        endcase
      end
    end
  end

  // next latch value; software write wins over side copies of the same cycle
  always_comb
  begin
    latch_d = latch_q;
    if (latch_wr)
      latch_d = bus_i.wdata;
    else if (low_rd)
      latch_d = pc_q[15:8];
    else if (first_clock_phase_i && !wake_i && !low_wr)
    begin
      case (req_i.op)
        PCPL_OP_RETURN:     latch_d = pc_q[15:8];
        PCPL_OP_SHORT_JUMP: latch_d = {pc_q[15:`PCPL_PAGE_LSB], req_i.opcode[`PCPL_SHORT_MSB:8]};
        default:            latch_d = latch_q;
      endcase
    end
  end

  // fetch address register, cleared by every reset kind
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pc_q <= `PCPL_RST_PC;
    else
      pc_q <= pc_d;
  end

  // holding latch register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      latch_q <= `PCPL_RST_LATCH;
    else
      latch_q <= latch_d;
  end

  // registered read data; the high byte itself has no address
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= bus_i.rd && (hit(bus_i, `PCPL_ADDR_LOW) || hit(bus_i, `PCPL_ADDR_LATCH));
      if (bus_i.rd && hit(bus_i, `PCPL_ADDR_LOW))
        rdata_o <= pc_q[7:0];
      else if (bus_i.rd && hit(bus_i, `PCPL_ADDR_LATCH))
        rdata_o <= latch_q;
      else
        rdata_o <= 8'h00;
    end
  end

  // skip flag marks the no-operation cycle that follows
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      forced_nop_o <= 1'b0;
    else if (first_clock_phase_i)
      forced_nop_o <= (req_i.op == PCPL_OP_SKIP) && !low_wr && !wake_i;
  end

  // output copies so outputs come straight from flip-flops
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_addr_o               <= `PCPL_RST_PC;
      fetch_high_holding_latch_o <= `PCPL_RST_LATCH;
    end
    else
    begin
      fetch_addr_o               <= pc_d;
      fetch_high_holding_latch_o <= latch_d;
    end
  end

  // checks on the decoder, bus and wake paths; each antecedent excludes the overriding cases
  a_seq_incr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && !low_wr && req_i.op == PCPL_OP_SEQ) |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("sequential fetch did not increment");
  a_idle_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!first_clock_phase_i && !wake_i) |=> pc_q == $past(pc_q))
    else $error("fetch address moved outside the first phase");
  a_skip_nop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && !low_wr && req_i.op == PCPL_OP_SKIP)
    |=> forced_nop_o && pc_q == $past(pc_q) + 16'h0001)
    else $error("skip did not force a no-operation");
  a_long_call: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && !low_wr && !latch_wr && !low_rd && req_i.op == PCPL_OP_LONG_CALL)
    |=> pc_q == {$past(latch_q), $past(req_i.opcode[7:0])} && latch_q == $past(latch_q))
    else $error("long call target wrong");
  a_low_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (low_rd && !latch_wr) |=> latch_q == $past(pc_q[15:8]) && rdata_o == $past(pc_q[7:0]))
    else $error("low read did not copy high byte");
  a_low_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && low_wr) |=> pc_q == {$past(latch_q), $past(bus_i.wdata)})
    else $error("low write target wrong");
  a_rmw_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (bus_i.rmw && hit(bus_i, `PCPL_ADDR_LOW) && !latch_wr) |=> latch_q == $past(latch_q))
    else $error("rmw changed latch");
  a_latch_wr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    latch_wr |=> latch_q == $past(bus_i.wdata))
    else $error("latch write lost");
  a_latch_rd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (bus_i.rd && hit(bus_i, `PCPL_ADDR_LATCH)) |=> rdata_valid_o && rdata_o == $past(latch_q))
    else $error("latch read data wrong");
  a_return_ld: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && !low_wr && !latch_wr && !low_rd && req_i.op == PCPL_OP_RETURN)
    |=> pc_q == $past(most_recent_stack_entry_i) && latch_q == $past(pc_q[15:8]))
    else $error("return load wrong");
  a_short_jump: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !wake_i && !low_wr && !latch_wr && !low_rd && req_i.op == PCPL_OP_SHORT_JUMP)
    |=> pc_q[12:0] == $past(req_i.opcode) && latch_q[4:0] == $past(req_i.opcode[12:8])
        && latch_q[7:5] == pc_q[15:13])
    else $error("short jump wrong");
  a_wake_vec: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wake_i && !global_interrupt_disable_i) |=> pc_q == $past(int_vector_i))
    else $error("wake did not vector");
  a_wake_seq: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wake_i && global_interrupt_disable_i) |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("masked wake did not step");
  a_keep_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (first_clock_phase_i && !latch_wr && !low_rd && (req_i.op == PCPL_OP_RET_KEEP || req_i.op == PCPL_OP_VECTOR))
    |=> $stable(latch_q))
    else $error("latch changed");

  // main scenarios that the checks above should see at least once
  c_long_call: cover property (@(posedge core_clk_i) first_clock_phase_i && req_i.op == PCPL_OP_LONG_CALL);
  c_return:    cover property (@(posedge core_clk_i) first_clock_phase_i && req_i.op == PCPL_OP_RETURN);
  c_low_write: cover property (@(posedge core_clk_i) first_clock_phase_i && low_wr);
  c_wake_vec:  cover property (@(posedge core_clk_i) wake_i && !global_interrupt_disable_i);
  c_skip:      cover property (@(posedge core_clk_i) forced_nop_o);

endmodule
`default_nettype wire

// ---- testbench/pcl_stack_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcpl_stack_model
#(
  parameter logic [15:0] VEC_ADDR = 16'h0010
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic [15:0] push_addr_i,
  output logic      [15:0] top_o,
  output logic      [15:0] vector_o
);
  // one-deep stack: returns only ever look at the latest entry
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      top_o <= 16'h0000;
    else if (push_i)
      top_o <= push_addr_i;
  end
  // exception logic hands a fixed vector
  assign vector_o = VEC_ADDR;
endmodule
`default_nettype wire

// ---- testbench/tb_program_counter_page_latch.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pcl_params.svh"
module tb_program_counter_page_latch;
  import pcpl_pkg::*;
  localparam logic [15:0] VEC = 16'h0010;
  localparam logic [7:0]  LO  = `PCPL_ADDR_LOW;
  localparam logic [7:0]  HI  = `PCPL_ADDR_LATCH;
  // bus access kinds, {rd, wr, rmw}
  localparam logic [2:0]  RD  = 3'b100;
  localparam logic [2:0]  WR  = 3'b010;
  localparam logic [2:0]  RMW = 3'b001;
  logic        clk = 1'b0, rst = 1'b1, q1 = 1'b0, wake = 1'b0, gid = 1'b1, push = 1'b0;
  logic [15:0] push_addr = 16'h0000, top, vec, pc, pc_e;
  logic [7:0]  lat, rdata, lat_e;
  logic        rvalid, nop;
  pcpl_req_t   req = '{PCPL_OP_HOLD, 13'h0000};
  pcpl_bus_t   bus = '0;
  int          n_errors = 0, cmp_count = 0, cycles = 0;
  pcpl_stack_model #(.VEC_ADDR(VEC)) stk (.core_clk_i(clk), .rst_i(rst), .push_i(push), .push_addr_i(push_addr),
    .top_o(top), .vector_o(vec));
  pcpl_page_latch dut (.core_clk_i(clk), .rst_i(rst), .first_clock_phase_i(q1), .req_i(req), .bus_i(bus),
    .most_recent_stack_entry_i(top), .int_vector_i(vec), .wake_i(wake), .global_interrupt_disable_i(gid),
    .fetch_addr_o(pc), .fetch_high_holding_latch_o(lat), .rdata_o(rdata), .rdata_valid_o(rvalid), .forced_nop_o(nop));
  // 10 MHz core clock
  always #50 clk = ~clk;
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_state();
    chk("fetch_addr", pc_e, pc);
    chk("holding_latch", {8'h00, lat_e}, {8'h00, lat});
  endtask
  // one request held over a single rising edge; outputs are settled on return
  task automatic step(input logic f, input pcpl_op_t op, input logic [12:0] opc, input pcpl_bus_t b, input logic w);
    @(negedge clk);
    q1 = f;
    req = '{op, opc};
    bus = b;
    wake = w;
    @(negedge clk);
    q1 = 1'b0;
    req = '{PCPL_OP_HOLD, 13'h0000};
    bus = '0;
    wake = 1'b0;
  endtask
  // bus-only cycle outside the first phase
  task automatic sb(input pcpl_bus_t b);
    step(1'b0, PCPL_OP_HOLD, 13'h0000, b, 1'b0);
  endtask
  // decoder request in the first phase, bus idle
  task automatic so(input pcpl_op_t op, input logic [12:0] opc);
    step(1'b1, op, opc, '0, 1'b0);
  endtask
  function automatic pcpl_bus_t bx(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
    return {k, a, d};
  endfunction
  task automatic push_entry(input logic [15:0] a);
    @(negedge clk);
    push = 1'b1;
    push_addr = a;
    @(negedge clk);
    push = 1'b0;
  endtask
  task automatic t_seq_skip();
    pc_e = `PCPL_RST_PC;
    lat_e = `PCPL_RST_LATCH;
    chk_state();
    so(PCPL_OP_SEQ, 13'h0000);
    pc_e = pc_e + 16'h0001;
    chk_state();
    so(PCPL_OP_SKIP, 13'h0000);
    pc_e = pc_e + 16'h0001;
    chk("forced_nop", 16'h0001, {15'h0000, nop});
    step(1'b0, PCPL_OP_SEQ, 13'h0000, bx(WR, LO, 8'h99), 1'b0);
    chk_state();
  endtask
  // computed jump, then short jump and long call from the new page
  task automatic t_jumps();
    sb(bx(WR, HI, 8'hA5));
    lat_e = 8'hA5;
    step(1'b1, PCPL_OP_SEQ, 13'h0000, bx(WR, LO, 8'h3C), 1'b0);
    pc_e = {lat_e, 8'h3C};
    chk_state();
    chk("forced_nop", 16'h0000, {15'h0000, nop});
    so(PCPL_OP_SHORT_JUMP, 13'h1ABC);
    lat_e = {pc_e[15:13], 5'h1A};
    pc_e = {pc_e[15:13], 13'h1ABC};
    chk_state();
    so(PCPL_OP_LONG_CALL, 13'h1F77);
    pc_e = {lat_e, 8'h77};
    chk_state();
  endtask
  task automatic t_read_rmw();
    sb(bx(WR, HI, 8'h11));
    sb(bx(RD, LO, 8'h00));
    lat_e = pc_e[15:8];
    chk_state();
    chk("rdata", {8'h00, pc_e[7:0]}, {8'h00, rdata});
    chk("rdata_valid", 16'h0001, {15'h0000, rvalid});
    sb(bx(RD, HI, 8'h00));
    chk("rdata_latch", {8'h00, lat_e}, {8'h00, rdata});
    chk_state();
    sb(bx(WR, HI, 8'h03));
    step(1'b1, PCPL_OP_SEQ, 13'h0000, bx(WR, LO, 8'hF0), 1'b0);
    sb(bx(WR, HI, 8'h05));
    lat_e = 8'h05;
    step(1'b1, PCPL_OP_SEQ, 13'h0000, bx(RMW, LO, 8'h20), 1'b0);
    pc_e = {lat_e, 8'h20};
    chk_state();
  endtask
  task automatic t_return_wake();
    sb(bx(WR, HI, 8'h66));
    push_entry(16'h4321);
    so(PCPL_OP_RETURN, 13'h0000);
    lat_e = pc_e[15:8];
    pc_e = 16'h4321;
    chk_state();
    push_entry(16'h2468);
    so(PCPL_OP_RET_KEEP, 13'h0000);
    pc_e = 16'h2468;
    chk_state();
    so(PCPL_OP_VECTOR, 13'h0000);
    pc_e = VEC;
    chk_state();
    step(1'b0, PCPL_OP_HOLD, 13'h0000, '0, 1'b1);
    pc_e = pc_e + 16'h0001;
    chk_state();
    gid = 1'b0;
    step(1'b0, PCPL_OP_HOLD, 13'h0000, '0, 1'b1);
    pc_e = VEC;
    chk_state();
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    pc_e = `PCPL_RST_PC;
    lat_e = `PCPL_RST_LATCH;
    chk_state();
  endtask
  // hang guard: the whole run needs well under 200 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_seq_skip();
    t_jumps();
    t_read_rmw();
    t_return_wake();
    conclude();
  end
endmodule
`default_nettype wire
